// ---- bench/i2c_host_model.sv ----
`timescale 1ns/1ps
module i2c_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h2a,  // Arbitrary value
  parameter int         HALF     = 4
) (
  input  wire logic i_clock,     // System clock
  input  wire logic i_sda_line,  // Resolved data line
  output logic      o_scl,       // Serial clock
  output logic      o_sda_low    // High pulls data low
);
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_clock);
  endtask

  // Data set while clock is low, sampled at the end of clock high
  task automatic bit_xfer(input logic b, output logic r);
    o_sda_low <= !b;
    wait_clk(HALF);
    o_scl <= 1'b1;
    wait_clk(HALF);
    r = i_sda_line;
    o_scl <= 1'b0;
    wait_clk(1);
  endtask

  task automatic start_cond;
    o_sda_low <= 1'b0;
    o_scl <= 1'b1;
    wait_clk(HALF);
    o_sda_low <= 1'b1;
    wait_clk(HALF);
    o_scl <= 1'b0;
    wait_clk(HALF);
  endtask

  task automatic stop_cond;
    o_sda_low <= 1'b1;
    wait_clk(HALF);
    o_scl <= 1'b1;
    wait_clk(HALF);
    o_sda_low <= 1'b0;
    wait_clk(HALF);
  endtask

  task automatic byte_out(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(d[i], r);
    bit_xfer(1'b1, r);
  endtask

  // Low byte of a pair goes before its high byte in 10-bit mode
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    wait_clk(1);
    start_cond();
    byte_out({DEV_ADDR, 1'b0});
    byte_out(a);
    byte_out(d);
    stop_cond();
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    logic r;
    wait_clk(1);
    start_cond();
    byte_out({DEV_ADDR, 1'b0});
    byte_out(a);
    stop_cond();
    start_cond();
    byte_out({DEV_ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, r);
      d[i] = r;
    end
    bit_xfer(1'b1, r);
    stop_cond();
  endtask
endmodule

// ---- bench/led_dimming_brightness_engine_tb.sv ----
`timescale 1ns/1ps
`define CHECK(a, e) begin checks++; if ((a) !== (e)) begin bad_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module led_dimming_brightness_engine_tb;
  import led_dim_pkg::*;
  localparam logic [6:0] DEV   = 7'h2a;  // Arbitrary value
  localparam int         SLOPE = 4;
  logic        i_clock  = 1'b0;
  logic        i_reset  = 1'b1;
  logic        i_enable = 1'b1;
  logic [9:0]  pwm      = 10'h000;
  logic [59:0] fb       = 60'h0;
  logic        scl, host_low, sda_out, sda_oe, dim_pwm, dc_mode;
  wire logic   sda_line;
  logic [9:0]  duty, ea, headroom;
  logic [7:0]  cur, rd;
  int          bad_count = 0;
  int          checks    = 0;
  int          n, s;
  logic [7:0]  rst_addr [8] = '{ADDR_MODE, ADDR_CFG, ADDR_CURRENT,
    ADDR_COMP_RATIO, ADDR_BRIGHT_MODE, ADDR_FADE_DITHER, ADDR_SOFT_START,
    ADDR_COMP_STOP};
  logic [7:0]  rst_val [8] = '{RST_MODE, RST_CFG, RST_CURRENT, RST_ZERO,
    RST_ZERO, RST_FADE_DITHER, RST_ZERO, RST_ZERO};
  logic [9:0]  hr_tbl [4] = '{HEADROOM_MV0, HEADROOM_MV1, HEADROOM_MV2,
    HEADROOM_MV3};
  logic [7:0]  md_val [4] = '{8'h01, 8'h01, 8'h02, 8'h03};
  logic [7:0]  md_adr [4] = '{ADDR_P1_LO, ADDR_P1_LO, ADDR_P2_LO, ADDR_P2_LO};
  logic [7:0]  md_byt [4] = '{8'hff, 8'h00, 8'hff, 8'h00};
  logic [9:0]  md_dut [4] = '{10'h200, 10'h200, 10'h200, 10'h000};
  int          md_code [4] = '{512, 0, 512, 0};

  always #4 i_clock = ~i_clock;
  assign sda_line = !(host_low || (sda_oe && !sda_out));

  led_dimming_brightness_engine #(.SLOPE_CYCLES(SLOPE), .DEV_ADDR(DEV))
  i_led_dimming_brightness_engine (
    .i_clock(i_clock), .i_reset(i_reset), .i_enable(i_enable),
    .i_pwm_input_duty(pwm), .i_channel_feedback_voltage(fb),
    .i_scl(scl), .i_sda(sda_line), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
    .o_dimming_pwm(dim_pwm), .o_dimming_output_duty(duty),
    .o_channel_current(cur), .o_error_amplifier_input(ea),
    .o_headroom_mv(headroom), .o_dc_mode(dc_mode));

  i2c_host_model #(.DEV_ADDR(DEV)) i_i2c_host_model (
    .i_clock(i_clock), .i_sda_line(sda_line), .o_scl(scl),
    .o_sda_low(host_low));

  function automatic logic [7:0] exp_cur(input int st, input int c,
                                         input int k, input int stop);
    int comp;
    comp = c;
    if (stop == 0 || (c >> 2) < stop)
      comp = c - c * (FULL_SCALE - c) * k / FULL_SCALE / RATIO_DIV;
    return 8'(st * comp / FULL_SCALE);
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_i2c_host_model.write_reg(a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    i_i2c_host_model.read_reg(a, rd);
    `CHECK(rd, e)
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge i_clock);
  endtask

  task automatic set_pwm(input logic [9:0] v);
    @(posedge i_clock);
    pwm <= v;
  endtask

  task automatic wait_duty(input logic [9:0] e);
    n = 0;
    while (duty !== e && n < 20000) begin
      @(posedge i_clock);
      n++;
    end
    tick(3);
  endtask

  task automatic wait_change(output int c);
    logic [9:0] v;
    v = duty;
    c = 0;
    while (duty === v && c < 5000) begin
      @(posedge i_clock);
      c++;
    end
  endtask

  // Third interval only: the first two may straddle a setting change
  task automatic step_len(output int c);
    wait_change(c);
    wait_change(c);
    wait_change(c);
  endtask

  task automatic final_report;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge i_clock);
    bad_count++;
    final_report();
  end

  initial begin
    tick(16);
    i_reset <= 1'b0;
    tick(1);
    `CHECK(headroom, HEADROOM_MV0)
    foreach (rst_addr[i]) rd_chk(rst_addr[i], rst_val[i]);
    wr(ADDR_COMP_STOP, 8'ha5);
    rd_chk(ADDR_COMP_STOP, 8'ha5);
    wr(8'h0c, 8'h55);
    rd_chk(8'h0c, 8'h00);
    wr(ADDR_COMP_STOP, 8'h00);
    for (int h = 0; h < 4; h++) begin
      wr(ADDR_BRIGHT_MODE, 8'(h << HEADROOM_LSB));
      `CHECK(headroom, hr_tbl[h])
    end
    @(posedge i_clock);
    fb <= {10'h3ff, 10'h100, 10'h0c8, 10'h050, 10'h2ff, 10'h1ff};
    tick(4);
    `CHECK(ea, 10'h050)
    @(posedge i_clock);
    fb <= {10'h011, 10'h100, 10'h0c8, 10'h050, 10'h2ff, 10'h1ff};
    tick(4);
    `CHECK(ea, 10'h011)
    wr(ADDR_FADE_DITHER, 8'h0c);
    set_pwm(10'h3ff);
    wait_duty(10'h3ff);
    `CHECK(duty, 10'h3ff)
    `CHECK(cur, RST_CURRENT)
    wr(ADDR_COMP_RATIO, 8'h1f);
    set_pwm(10'h200);
    wait_duty(10'h200);
    `CHECK(cur, exp_cur(146, 512, 31, 0))
    n = 0;
    repeat (1023) begin
      @(posedge i_clock);
      n += int'(dim_pwm === 1'b1);
    end
    `CHECK(n, 512)
    wr(ADDR_COMP_STOP, 8'h40);
    `CHECK(cur, exp_cur(146, 512, 31, 8'h40))
    wr(ADDR_COMP_STOP, 8'h81);
    wr(ADDR_CURRENT, 8'hff);
    `CHECK(cur, exp_cur(255, 512, 31, 8'h81))
    wr(ADDR_COMP_RATIO, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(md_adr[m], md_byt[m]);
      wr(ADDR_BRIGHT_MODE, md_val[m]);
      wait_duty(md_dut[m]);
      `CHECK(duty, md_dut[m])
      `CHECK(cur, exp_cur(255, md_code[m], 0, 0))
    end
    wr(ADDR_BRIGHT_MODE, 8'h00);
    wr(ADDR_P1_LO, 8'h80);
    set_pwm(10'h3ff);
    wr(ADDR_MODE, 8'h42);
    wait_duty(10'h202);
    `CHECK(duty, 10'h202)
    `CHECK(cur, exp_cur(255, 514, 0, 0))
    wr(ADDR_CFG, 8'hf6);
    wr(ADDR_P1_LO, 8'h04);
    tick(8);
    `CHECK(duty, 10'h202)
    wr(ADDR_P1_HI, 8'h00);
    wait_duty(10'h004);
    `CHECK(duty, 10'h004)
    wr(ADDR_MODE, 8'hc2);
    `CHECK(duty, 10'h004)
    `CHECK(dc_mode, 1'b0)
    wr(ADDR_MODE, 8'hc3);
    tick(4);
    `CHECK(dc_mode, 1'b1)
    `CHECK(duty, 10'h3ff)
    `CHECK(dim_pwm, 1'b1)
    for (int f = 0; f < 4; f++) begin
      s = FADE_BASE_CYCLES << f;
      wr(ADDR_FADE_DITHER, 8'(8'h0c | (f << FADE_LSB)));
      wr(ADDR_P1_LO, 8'h00);
      wr(ADDR_P1_HI, 8'h00);
      n = 0;
      while (dim_pwm !== 1'b0 && n < 3000) begin
        @(posedge i_clock);
        n++;
      end
      `CHECK(n > 3 * s - 16 && n <= 4 * s, 1'b1)
      wr(ADDR_P1_LO, 8'h04);
      wr(ADDR_P1_HI, 8'h00);
      tick(5 * s);
    end
    wr(ADDR_MODE, RST_MODE);
    wr(ADDR_FADE_DITHER, RST_FADE_DITHER);
    wr(ADDR_BRIGHT_MODE, 8'h00);
    wait_duty(10'h3ff);
    set_pwm(10'h000);
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_BRIGHT_MODE, 8'(c << SLOPE_LSB));
      step_len(n);
      `CHECK(n, SLOPE << (c < 2 ? 0 : c - 1))
    end
    wr(ADDR_BRIGHT_MODE, 8'h00);
    set_pwm(10'h3ff);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_SOFT_START, 8'(k));
      @(posedge i_clock);
      i_enable <= ~i_enable;
      step_len(n);
      `CHECK(n, SLOPE << k)
    end
    final_report();
  end
endmodule

// ---- hdl/led_dim_pkg.sv ----
package led_dim_pkg;
  localparam int NUM_REGS = 12;
  localparam logic [7:0] ADDR_MODE        = 8'h00;
  localparam logic [7:0] ADDR_CFG         = 8'h01;
  localparam logic [7:0] ADDR_CURRENT     = 8'h02;
  localparam logic [7:0] ADDR_COMP_RATIO  = 8'h03;
  localparam logic [7:0] ADDR_P1_LO       = 8'h04;
  localparam logic [7:0] ADDR_P1_HI       = 8'h05;
  localparam logic [7:0] ADDR_P2_LO       = 8'h06;
  localparam logic [7:0] ADDR_P2_HI       = 8'h07;
  localparam logic [7:0] ADDR_BRIGHT_MODE = 8'h08;
  localparam logic [7:0] ADDR_FADE_DITHER = 8'h09;
  localparam logic [7:0] ADDR_SOFT_START  = 8'h0a;
  localparam logic [7:0] ADDR_COMP_STOP   = 8'h0b;
  localparam logic [7:0] RST_MODE         = 8'h40;
  localparam logic [7:0] RST_CFG          = 8'h76;
  localparam logic [7:0] RST_CURRENT      = 8'h92;
  localparam logic [7:0] RST_FADE_DITHER  = 8'h1c;
  localparam logic [7:0] RST_ZERO         = 8'h00;
  localparam int BIT_26K = 7;
  localparam int BIT_REG_SRC = 1;
  localparam int BIT_MIX = 0;
  localparam int MIXDUTY_LSB = 2;
  localparam int BIT_TEN = 7;
  localparam int ADV_LSB = 0;
  localparam int HEADROOM_LSB = 2;
  localparam int SLOPE_LSB = 4;
  localparam int FADE_LSB = 5;
  localparam int DITHER_EN_BIT = 4;
  localparam int SOFT_LSB = 0;
  localparam int FULL_SCALE = 1023;
  localparam int RATIO_DIV = 31;
  localparam int CODE_W = 10;
  localparam int CLOCK_MHZ = 125;
  localparam int FADE_BASE_NS = 500;
  localparam int FADE_BASE_CYCLES = FADE_BASE_NS * CLOCK_MHZ / 1000;
  localparam int SLOPE_BASE_US = 7800;
  localparam int SLOPE_STEP_CYCLES =
    SLOPE_BASE_US * CLOCK_MHZ / FULL_SCALE;
  localparam logic [9:0] HEADROOM_MV0 = 10'h1f4;
  localparam logic [9:0] HEADROOM_MV1 = 10'h23a;
  localparam logic [9:0] HEADROOM_MV2 = 10'h258;
  localparam logic [9:0] HEADROOM_MV3 = 10'h2bc;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ACK_A, ST_REG, ST_ACK_R, ST_WDATA, ST_ACK_W,
    ST_RDATA, ST_RACK
  } i2c_state_t;
endpackage

// ---- hdl/led_dimming_brightness_engine.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - Current is setting/1023 times code minus code*(1023-code)*k/1023/31.
// - An 8-bit stop duty, reset zero, sets where compensation stops.
// - The compensated code comes from PWM duty or brightness pair 1 or 2.
// - The current term of the formula is the 8-bit current setting.
// - With the source bit clear, plain mode follows PWM input; multiplied mode scales the current code by pair 1, the output duty stays PWM.
// - 26K plus register source takes pair 1; with mix and 00 it is DC.
// - The lowest feedback drives the amplifier; headroom is 500..700 mV.
// - In DC mode each ramp step lasts 0.5, 1, 2 or 4 us.
// - Soft-start ramps up and down are stretched by 1, 2, 4 or 8.
// - Dither slope sets 7.8 ms to 500 ms full ramp; enable defaults on.
// - In 10-bit mode a pair changes on its high write, not on its low write.
// - The source bit picks the PWM pin when clear, pair 1 when set.
module led_dimming_brightness_engine
  import led_dim_pkg::*;
#(
  parameter int SLOPE_CYCLES = SLOPE_STEP_CYCLES,
  parameter logic [6:0] DEV_ADDR = 7'h2a  // Arbitrary value
) (
  input  wire logic        i_clock,                    // System clock
  input  wire logic        i_reset,                    // Sync reset
  input  wire logic        i_enable,                   // Driver enable
  input  wire logic [9:0]  i_pwm_input_duty,           // Measured duty
  input  wire logic [59:0] i_channel_feedback_voltage, // Six 10-bit FB
  input  wire logic        i_scl,                      // Serial clock
  input  wire logic        i_sda,                      // Serial data in
  output logic             o_sda_out,                  // Data out level
  output logic             o_sda_oe,                   // Data drive enable
  output logic             o_dimming_pwm,              // Dimming pin
  output logic [9:0]       o_dimming_output_duty,      // Duty code
  output logic [7:0]       o_channel_current,          // Channel current
  output logic [9:0]       o_error_amplifier_input,    // Lowest feedback
  output logic [9:0]       o_headroom_mv,              // Headroom target
  output logic             o_dc_mode                   // DC variant active
);
  function automatic logic [9:0] mul10(input logic [9:0] a,
                                       input logic [9:0] b);
    logic [20:0] p;
    p = 21'(a) * 21'(b) + 21'(a);
    return p[19:10];
  endfunction

  function automatic logic [9:0] compensate(input logic [9:0] c,
                                            input logic [4:0] k);
    logic [27:0] t;
    t = 28'(c) * 28'(10'(FULL_SCALE) - c) * 28'(k);
    t = t / 28'(FULL_SCALE * RATIO_DIV);
    return c - t[9:0];
  endfunction

  function automatic logic [9:0] pair_code(input logic [7:0] lo,
                                           input logic [7:0] hi,
                                           input logic ten);
    return ten ? {hi[1:0], lo} : {lo, lo[7:6]};
  endfunction

  logic [7:0]  regs_reg [NUM_REGS];
  logic [9:0]  p1_code_reg, p2_code_reg;
  logic [9:0]  target_reg, applied_reg;
  logic [9:0]  pwm_cnt_reg;
  logic [22:0] step_cnt_reg;
  logic        soft_reg, enable_q_reg;
  i2c_state_t  state_reg;
  logic        scl_q_reg, sda_q_reg, rw_reg, first_reg;
  logic [3:0]  bit_cnt_reg;
  logic [7:0]  shift_reg, ptr_reg;

  // Register fields
  wire logic       ten_bit   = regs_reg[1][BIT_TEN];
  wire logic       reg_src   = regs_reg[0][BIT_REG_SRC];
  wire logic       sel_26k   = regs_reg[0][BIT_26K];
  wire logic       mix       = regs_reg[0][BIT_MIX];
  wire logic [1:0] mix_duty  = regs_reg[0][MIXDUTY_LSB +: 2];
  wire logic [7:0] channel_current_setting      = regs_reg[2];
  wire logic [4:0] ratio_k   = regs_reg[3][4:0];
  wire logic [1:0] adv_sel   = regs_reg[8][ADV_LSB +: 2];
  wire logic [1:0] headroom  = regs_reg[8][HEADROOM_LSB +: 2];
  wire logic [2:0] slope     = regs_reg[8][SLOPE_LSB +: 3];
  wire logic       dither_en = regs_reg[9][DITHER_EN_BIT];
  wire logic [1:0] fade      = regs_reg[9][FADE_LSB +: 2];
  wire logic [1:0] soft_mul  = regs_reg[10][SOFT_LSB +: 2];
  wire logic [7:0] comp_stop = regs_reg[11];

  // Brightness source and mode selection
  wire logic dc_mode = sel_26k & reg_src & mix &
                       (mix_duty == 2'b00);
  wire logic [9:0] base_code = reg_src ? p1_code_reg
                             : i_pwm_input_duty;
  wire logic [9:0] mul1_code = reg_src ? p1_code_reg
                             : mul10(i_pwm_input_duty, p1_code_reg);
  wire logic [9:0] mul2_code = mul10(base_code, p2_code_reg);
  wire logic [9:0] sel_code =
    (sel_26k & reg_src) ? p1_code_reg
    : (adv_sel == 2'b00) ? base_code
    : (adv_sel == 2'b01) ? mul1_code
    : mul2_code;
  wire logic [9:0] target_next = i_enable ? sel_code : 10'h000;
  wire logic duty_is_pwm = (adv_sel == 2'b01) & ~reg_src;

  // Compensation and current
  wire logic comp_off = (comp_stop != 8'h00) &&
                        (i_pwm_input_duty[9:2] >= comp_stop);
  wire logic [9:0] comp_code = comp_off ? applied_reg
                             : compensate(applied_reg, ratio_k);
  wire logic [17:0] cur_prod = 18'(channel_current_setting) * 18'(comp_code);
  wire logic [17:0] cur_quot = cur_prod / 18'(FULL_SCALE);
  wire logic [7:0] current_next = cur_quot[7:0];

  // Ramp step length
  wire logic [2:0]  slope_sh = (slope < 3'd2) ? 3'd0 : slope - 3'd1;
  wire logic [22:0] fade_len = 23'(FADE_BASE_CYCLES) << fade;
  wire logic [22:0] slope_len = 23'(SLOPE_CYCLES) << slope_sh;
  wire logic [22:0] base_len = dc_mode ? fade_len : slope_len;
  wire logic [22:0] step_len = soft_reg ? base_len << soft_mul
                             : base_len;
  wire logic jump = ~dc_mode & ~dither_en & ~soft_reg;
  wire logic ramping = applied_reg != target_reg;
  wire logic step_due = step_cnt_reg >= step_len - 23'd1;
  wire logic [9:0] applied_next =
    ~ramping ? applied_reg
    : jump ? target_reg
    : ~step_due ? applied_reg
    : (applied_reg < target_reg) ? applied_reg + 10'd1
    : applied_reg - 10'd1;

  // Lowest feedback selection
  logic [9:0] fb_min;
  always_comb begin
    fb_min = i_channel_feedback_voltage[9:0];
    for (int i = 1; i < 6; i++) begin
      if (i_channel_feedback_voltage[i*10 +: 10] < fb_min) begin
        fb_min = i_channel_feedback_voltage[i*10 +: 10];
      end
    end
  end
  wire logic [9:0] headroom_next =
    (headroom == 2'b00) ? HEADROOM_MV0 : (headroom == 2'b01) ?
    HEADROOM_MV1 : (headroom == 2'b10) ? HEADROOM_MV2
    : HEADROOM_MV3;

  // Duty counter
  wire logic [9:0] duty_src = duty_is_pwm ? i_pwm_input_duty : applied_reg;
  wire logic [9:0] cnt_next = (pwm_cnt_reg >= 10'(FULL_SCALE - 1)) ?
                              10'h000 : pwm_cnt_reg + 10'd1;
  wire logic pwm_next = dc_mode ? (applied_reg != 10'h000)
                      : (pwm_cnt_reg < duty_src);

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      target_reg <= 10'h000;
      applied_reg <= 10'h000;
      step_cnt_reg <= 23'h000000;
      soft_reg <= 1'b0;
      enable_q_reg <= 1'b0;
      pwm_cnt_reg <= 10'h000;
    end else begin
      target_reg <= target_next;
      applied_reg <= applied_next;
      step_cnt_reg <= (~ramping | step_due) ? 23'h000000
                    : step_cnt_reg + 23'd1;
      enable_q_reg <= i_enable;
      if (i_enable != enable_q_reg) begin
        soft_reg <= 1'b1;
      end else if (~ramping) begin
        soft_reg <= 1'b0;
      end
      pwm_cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_dimming_pwm <= 1'b0;
      o_dimming_output_duty <= 10'h000;
      o_channel_current <= 8'h00;
      o_error_amplifier_input <= 10'h000;
      o_headroom_mv <= HEADROOM_MV0;
      o_dc_mode <= 1'b0;
    end else begin
      o_dimming_pwm <= pwm_next;
      o_dimming_output_duty <= dc_mode ? 10'(FULL_SCALE) : duty_src;
      o_channel_current <= current_next;
      o_error_amplifier_input <= fb_min;
      o_headroom_mv <= headroom_next;
      o_dc_mode <= dc_mode;
    end
  end

  // Serial register port
  wire logic scl_rise = i_scl & ~scl_q_reg;
  wire logic scl_fall = ~i_scl & scl_q_reg;
  wire logic start_c = scl_q_reg & i_scl & sda_q_reg & ~i_sda;
  wire logic stop_c = scl_q_reg & i_scl & ~sda_q_reg & i_sda;
  wire logic byte_in = scl_fall & (bit_cnt_reg == 4'd8);
  wire logic wr_strobe = byte_in & (state_reg == ST_WDATA);
  wire logic addr_hit = shift_reg[7:1] == DEV_ADDR;
  wire logic [7:0] rd_data = (ptr_reg < 8'(NUM_REGS)) ?
                             regs_reg[ptr_reg[3:0]] : 8'h00;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_reg <= ST_IDLE;
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
      rw_reg <= 1'b0;
      first_reg <= 1'b0;
      bit_cnt_reg <= 4'd0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      o_sda_oe <= 1'b0;
      o_sda_out <= 1'b0;
    end else begin
      scl_q_reg <= i_scl;
      sda_q_reg <= i_sda;
      if (start_c) begin
        state_reg <= ST_ADDR;
        bit_cnt_reg <= 4'd0;
        o_sda_oe <= 1'b0;
      end else if (stop_c) begin
        state_reg <= ST_IDLE;
        o_sda_oe <= 1'b0;
      end else begin
        case (state_reg)
          ST_ADDR, ST_REG, ST_WDATA: begin
            if (scl_rise && bit_cnt_reg < 4'd8) begin
              shift_reg <= {shift_reg[6:0], i_sda};
              bit_cnt_reg <= bit_cnt_reg + 4'd1;
            end
            if (byte_in) begin
              bit_cnt_reg <= 4'd0;
              if (state_reg == ST_ADDR) begin
                rw_reg <= shift_reg[0];
                state_reg <= addr_hit ? ST_ACK_A : ST_IDLE;
                o_sda_oe <= addr_hit;
              end else if (state_reg == ST_REG) begin
                ptr_reg <= shift_reg;
                state_reg <= ST_ACK_R;
                o_sda_oe <= 1'b1;
              end else begin
                ptr_reg <= ptr_reg + 8'd1;
                state_reg <= ST_ACK_W;
                o_sda_oe <= 1'b1;
              end
            end
          end
          ST_ACK_A, ST_ACK_R, ST_ACK_W: begin
            if (scl_fall) begin
              if (state_reg == ST_ACK_A && rw_reg) begin
                shift_reg <= rd_data;
                o_sda_oe <= ~rd_data[7];
                state_reg <= ST_RDATA;
              end else begin
                o_sda_oe <= 1'b0;
                state_reg <= (state_reg == ST_ACK_A) ? ST_REG : ST_WDATA;
              end
            end
          end
          ST_RDATA: begin
            if (scl_fall) begin
              bit_cnt_reg <= bit_cnt_reg + 4'd1;
              shift_reg <= {shift_reg[6:0], 1'b0};
              o_sda_oe <= (bit_cnt_reg == 4'd7) ? 1'b0 : ~shift_reg[6];
              if (bit_cnt_reg == 4'd7) begin
                ptr_reg <= ptr_reg + 8'd1;
                state_reg <= ST_RACK;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              first_reg <= ~i_sda;
            end
            if (scl_fall) begin
              bit_cnt_reg <= 4'd0;
              shift_reg <= rd_data;
              o_sda_oe <= first_reg & ~rd_data[7];
              state_reg <= first_reg ? ST_RDATA : ST_IDLE;
            end
          end
          default: begin
            o_sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // Register file and brightness pair latching
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_reg[i] <= RST_ZERO;
      end
      regs_reg[0] <= RST_MODE;
      regs_reg[1] <= RST_CFG;
      regs_reg[2] <= RST_CURRENT;
      regs_reg[9] <= RST_FADE_DITHER;
      p1_code_reg <= 10'h000;
      p2_code_reg <= 10'h000;
    end else if (wr_strobe && ptr_reg < 8'(NUM_REGS)) begin
      regs_reg[ptr_reg[3:0]] <= shift_reg;
      if (ptr_reg == ADDR_P1_HI && ten_bit) begin
        p1_code_reg <= pair_code(regs_reg[4], shift_reg, 1'b1);
      end else if (ptr_reg == ADDR_P1_LO && !ten_bit) begin
        p1_code_reg <= pair_code(shift_reg, 8'h00, 1'b0);
      end
      if (ptr_reg == ADDR_P2_HI && ten_bit) begin
        p2_code_reg <= pair_code(regs_reg[6], shift_reg, 1'b1);
      end else if (ptr_reg == ADDR_P2_LO && !ten_bit) begin
        p2_code_reg <= pair_code(shift_reg, 8'h00, 1'b0);
      end
    end
  end

  chk_current_formula: assert property (@(posedge i_clock)
    disable iff (i_reset) (ratio_k == 5'd0) |=> o_channel_current ==
    8'((18'($past(channel_current_setting)) * 18'($past(applied_reg))) / 18'(FULL_SCALE)))
    else $error("current not setting times code");
  chk_comp_stop: assert property (@(posedge i_clock)
    disable iff (i_reset) (comp_stop != 8'h00 &&
    i_pwm_input_duty[9:2] >= comp_stop) |=> o_channel_current ==
    8'((18'($past(channel_current_setting)) * 18'($past(applied_reg))) / 18'(FULL_SCALE)))
    else $error("compensation applied past stop duty");
  chk_comp_bound: assert property (@(posedge i_clock)
    disable iff (i_reset) comp_code <= applied_reg)
    else $error("compensation raised the code");
  chk_reg_source: assert property (@(posedge i_clock)
    disable iff (i_reset) (i_enable && reg_src && adv_sel == 2'b00)
    |=> target_reg == $past(p1_code_reg))
    else $error("register source not taken");
  chk_pwm_source: assert property (@(posedge i_clock)
    disable iff (i_reset) (i_enable && !reg_src && adv_sel == 2'b00)
    |=> target_reg == $past(i_pwm_input_duty))
    else $error("pwm source not taken");
  chk_dc_level: assert property (@(posedge i_clock)
    disable iff (i_reset) (dc_mode && applied_reg != 10'h000)
    |=> o_dimming_pwm && o_dc_mode)
    else $error("dc variant not steady");
  chk_lowest_fb: assert property (@(posedge i_clock)
    disable iff (i_reset) 1'b1 |=> o_error_amplifier_input <=
    $past(i_channel_feedback_voltage[29:20]))
    else $error("feedback minimum wrong");
  chk_ramp_step: assert property (@(posedge i_clock)
    disable iff (i_reset) (!$past(jump) && applied_reg != $past(applied_reg))
    |-> $past(step_due))
    else $error("ramp stepped early");
  chk_fade_len: assert property (@(posedge i_clock)
    disable iff (i_reset) (dc_mode && !soft_reg && fade == 2'b00)
    |-> step_len == 23'(FADE_BASE_CYCLES))
    else $error("fade step length wrong");
  chk_soft_len: assert property (@(posedge i_clock)
    disable iff (i_reset) (soft_reg && soft_mul == 2'b11)
    |-> step_len == base_len << 3)
    else $error("soft start stretch wrong");
  chk_ten_hold: assert property (@(posedge i_clock)
    disable iff (i_reset) (wr_strobe && ten_bit && ptr_reg == ADDR_P1_LO)
    |=> $stable(p1_code_reg))
    else $error("pair changed on low write");
endmodule
